// file: shared/tmd_pkg.sv
// Purpose: shared constants and types of the test, multiply and divide unit
// Assumes: 32-bit operands, register indices of four bits
// Notes: register offsets are byte addresses on the plain register port
package tmd_pkg;
	// ==========================================================
	// widths and timing
	localparam int TMD_XLEN = 32;
	localparam int TMD_RIDX_W = 4;
	localparam int TMD_DIV_STEPS = 32;
	localparam int TMD_ADDR_W = 8;
	localparam int TMD_CNT_W = 6;

	// ==========================================================
	// register map
	localparam logic [7:0] TMD_REG_CTRL = 8'h00;
	localparam logic [7:0] TMD_REG_STAT = 8'h04;
	localparam logic [7:0] TMD_REG_OPS = 8'h08;
	localparam int TMD_CTRL_TRAP_BIT = 0;
	localparam int TMD_STAT_BUSY_BIT = 0;
	localparam int TMD_STAT_DZ_BIT = 1;
	localparam logic TMD_CTRL_TRAP_RST = 1'h0;

	// ==========================================================
	// operation codes
	typedef enum logic [3:0] {
		OP_TEST_AND = 4'h0,
		OP_TEST_XOR = 4'h1,
		OP_MUL = 4'h2,
		OP_MLA = 4'h3,
		OP_MLS = 4'h4,
		OP_ULONG = 4'h5,
		OP_ULONG_ACC = 4'h6,
		OP_SLONG = 4'h7,
		OP_SLONG_ACC = 4'h8,
		OP_SQUOT = 4'h9,
		OP_UQUOT = 4'hA
	} tmd_op_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} tmd_flags_t;

	typedef struct packed {
		tmd_op_t op;
		logic set_flags;                  // flag-update variant
		logic shift_c;                    // shifter carry of the flexible operand
		logic shift_c_vld;                // shifter produced a carry
		logic rd_given;                   // destination named
		logic [TMD_RIDX_W-1:0] rd_idx;    // destination or result low index
		logic [TMD_RIDX_W-1:0] rn_idx;    // first source index
		logic [TMD_RIDX_W-1:0] rhi_idx;   // result high index
		logic [TMD_XLEN-1:0] first;
		logic [TMD_XLEN-1:0] second;
		logic [TMD_XLEN-1:0] addend;
		logic [TMD_XLEN-1:0] acc_hi;
		logic [TMD_XLEN-1:0] acc_lo;
	} tmd_req_t;

	typedef struct packed {
		logic wr_lo;
		logic wr_hi;
		logic [TMD_RIDX_W-1:0] lo_idx;
		logic [TMD_RIDX_W-1:0] hi_idx;
		logic [TMD_XLEN-1:0] lo_data;
		logic [TMD_XLEN-1:0] hi_data;
		tmd_flags_t flags;
		tmd_flags_t flag_we;
	} tmd_rsp_t;
endpackage

// file: hdl/tmd_divider.sv
// Purpose: iterative restoring divider, one quotient bit per clock
// Assumes: divisor is never zero at start; caller filters that case
// Notes: quotient truncates towards zero for both signed and unsigned
module tmd_divider #(
	parameter int W = tmd_pkg::TMD_XLEN
) (
	input wire logic core_clk_i,          // core clock
	input wire logic rst_n_i,             // sync reset, active low
	input wire logic start_i,             // one-cycle start pulse
	input wire logic signed_i,            // two's complement operands
	input wire logic [W-1:0] dividend_i,  // value to be divided
	input wire logic [W-1:0] divisor_i,   // nonzero divisor
	output logic busy_o,                  // iteration in progress
	output logic done_o,                  // one-cycle result pulse
	output logic [W-1:0] quotient_o       // valid while done_o
);
	import tmd_pkg::*;

	logic busy_r;
	logic fin_r;
	logic neg_r;
	logic [TMD_CNT_W-1:0] cnt_r;
	logic [W-1:0] rem_r;
	logic [W-1:0] quo_r;
	logic [W-1:0] dvs_r;
	logic [W:0] trial;
	logic [W-1:0] mag_a;
	logic [W-1:0] mag_b;

	// ==========================================================
	// magnitudes; sign is reapplied at the end so rounding is towards zero
	assign mag_a = (signed_i && dividend_i[W-1]) ? W'(-dividend_i) : dividend_i; // RULE19
	assign mag_b = (signed_i && divisor_i[W-1]) ? W'(-divisor_i) : divisor_i;
	assign trial = {rem_r, quo_r[W-1]} - {1'b0, dvs_r};

	// shift and subtract loop
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			busy_r <= 1'b0;
			fin_r <= 1'b0;
			neg_r <= 1'b0;
			cnt_r <= '0;
			rem_r <= '0;
			quo_r <= '0;
			dvs_r <= '0;
		end else if (start_i) begin
			busy_r <= 1'b1;
			fin_r <= 1'b0;
			neg_r <= signed_i && (dividend_i[W-1] ^ divisor_i[W-1]); // RULE17
			cnt_r <= TMD_CNT_W'(TMD_DIV_STEPS);
			rem_r <= '0;
			quo_r <= mag_a;
			dvs_r <= mag_b;
		end else if (busy_r) begin
			if (!trial[W]) begin
				rem_r <= trial[W-1:0];
				quo_r <= {quo_r[W-2:0], 1'b1};
			end else begin
				rem_r <= {rem_r[W-2:0], quo_r[W-1]};
				quo_r <= {quo_r[W-2:0], 1'b0};
			end
			cnt_r <= cnt_r - 1'b1;
			busy_r <= (cnt_r != 1'b1);
			fin_r <= (cnt_r == 1'b1);
		end else begin
			fin_r <= 1'b0;
		end
	end

	assign busy_o = busy_r;
	assign done_o = fin_r;
	// most negative by minus one wraps to itself, as two's complement does
	assign quotient_o = neg_r ? W'(-quo_r) : quo_r; // RULE18
endmodule // tmd_divider

// file: hdl/tmd_unit.sv
// Purpose: test, multiply and divide datapath beside the register file
// Assumes: decoder offers one request at a time with valid and ready
// Notes: divide by a nonzero divisor runs iteratively; every other operation answers next cycle
// Notes on behaviour
// (RULE1) bit test ANDs first operand with flexible operand, sets flags, writes nothing.
// (RULE2) equivalence test XORs first and flexible operand, sets flags, discards result.
// (RULE3) tests set negative and zero, carry from shifter, keep overflow.
// (RULE4) low-word multiply writes low 32 product bits to destination.
// (RULE5) accumulate multiply adds addend to product, writes low 32 bits.
// (RULE6) subtract multiply takes product from addend, writes low 32 bits.
// (RULE7) 32-bit multiply results ignore signedness; one datapath serves both.
// (RULE8) flag-update multiply sets negative and zero, keeps carry and overflow.
// (RULE9) issuer uses flag-update multiply only with low registers, dest equals second.
// (RULE10) multiply with no destination named writes to first source register.
// (RULE11) unsigned long product splits 64-bit product over low and high registers.
// (RULE12) unsigned long accumulate adds product to 64-bit pair, writes pair back.
// (RULE13) signed long product splits signed 64-bit product over the pair.
// (RULE14) signed long accumulate adds signed product to the pair, writes back.
// (RULE15) long multiplies never change any condition flag.
// (RULE16) issuer names two different registers for the long result pair.
// (RULE17) signed quotient divides as two's complement, writes destination.
// (RULE18) unsigned quotient divides as unsigned integers, writes destination.
// (RULE19) inexact quotients round towards zero.
// (RULE20) both divisions leave all condition flags unchanged.
// (RULE21) zero divisor without trap writes zero, flags untouched.
// (RULE22) long accumulate wraps modulo two to the sixty-four.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module tmd_unit (
	input wire logic core_clk_i,                          // core clock, 250 MHz
	input wire logic rst_n_i,                             // sync reset, active low
	input wire logic req_valid_i,                         // request offered
	output logic req_ready_o,                             // request can be taken
	input wire tmd_pkg::tmd_req_t req_i,                  // operation and operands
	input wire tmd_pkg::tmd_flags_t flags_i,              // current status flags
	output logic rsp_valid_o,                             // one-cycle answer pulse
	output tmd_pkg::tmd_rsp_t rsp_o,                      // writeback and flags
	output logic div_trap_o,                              // divide-by-zero trap pulse
	input wire logic [tmd_pkg::TMD_ADDR_W-1:0] reg_addr_i, // register address
	input wire logic [tmd_pkg::TMD_XLEN-1:0] reg_wdata_i, // register write data
	input wire logic reg_wr_i,                            // register write strobe
	input wire logic reg_rd_i,                            // register read strobe
	output logic [tmd_pkg::TMD_XLEN-1:0] reg_rdata_o      // read data, next cycle
);
	import tmd_pkg::*;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_DIV = 1'b1
	} tmd_state_t;

	tmd_state_t state_r;
	tmd_state_t state_nxt;
	tmd_rsp_t rsp_r;
	tmd_rsp_t rsp_nxt;
	logic rsp_valid_r;
	logic trap_r;
	logic ctrl_trap_r;
	logic dz_r;
	logic [TMD_XLEN-1:0] ops_r;
	logic [TMD_XLEN-1:0] rdata_r;
	logic [TMD_RIDX_W-1:0] pend_idx_r;
	logic take;
	logic is_div;
	logic div_zero;
	logic div_go;
	logic div_busy;
	logic div_done;
	logic [TMD_XLEN-1:0] quotient;
	logic sgn;
	logic [2*TMD_XLEN-1:0] ext_a;
	logic [2*TMD_XLEN-1:0] ext_b;
	logic [2*TMD_XLEN-1:0] prod;
	logic [2*TMD_XLEN-1:0] long_sum;
	logic [TMD_XLEN-1:0] test_res;
	logic [TMD_XLEN-1:0] mla_res;
	logic [TMD_XLEN-1:0] mls_res;
	logic [TMD_RIDX_W-1:0] dflt_idx;

	// ==========================================================
	// request acceptance
	assign take = req_valid_i && req_ready_o;
	assign req_ready_o = (state_r == ST_IDLE);
	assign is_div = (req_i.op == OP_SQUOT) || (req_i.op == OP_UQUOT);
	assign div_zero = (req_i.second == '0);
	// zero divisor never reaches the divider; it answers next cycle
	assign div_go = take && is_div && !div_zero;

	// ==========================================================
	// shared multiplier
	// sign extension only matters for the high word, so low results agree
	assign sgn = (req_i.op == OP_SLONG) || (req_i.op == OP_SLONG_ACC); // RULE13
	assign ext_a = {{TMD_XLEN{sgn & req_i.first[TMD_XLEN-1]}}, req_i.first};
	assign ext_b = {{TMD_XLEN{sgn & req_i.second[TMD_XLEN-1]}}, req_i.second};
	assign prod = ext_a * ext_b; // RULE7
	// carry out of the high word is dropped by the 64-bit width
	assign long_sum = prod + {req_i.acc_hi, req_i.acc_lo}; // RULE22
	assign mla_res = prod[TMD_XLEN-1:0] + req_i.addend; // RULE5
	assign mls_res = req_i.addend - prod[TMD_XLEN-1:0]; // RULE6
	assign test_res = (req_i.op == OP_TEST_AND) ? (req_i.first & req_i.second) // RULE1
		: (req_i.first ^ req_i.second); // RULE2
	assign dflt_idx = req_i.rd_given ? req_i.rd_idx : req_i.rn_idx; // RULE10

	// ==========================================================
	// single-cycle answer
	always_comb begin
		rsp_nxt = '0;
		rsp_nxt.flags = flags_i;
		rsp_nxt.lo_idx = dflt_idx;
		rsp_nxt.hi_idx = req_i.rhi_idx;
		unique case (req_i.op)
			OP_TEST_AND, OP_TEST_XOR: begin
				// no register write; only flags leave the unit
				rsp_nxt.flags.n = test_res[TMD_XLEN-1]; // RULE3
				rsp_nxt.flags.z = (test_res == '0);
				rsp_nxt.flags.c = req_i.shift_c_vld ? req_i.shift_c : flags_i.c;
				rsp_nxt.flag_we = '{n: 1'b1, z: 1'b1, c: req_i.shift_c_vld, v: 1'b0}; // RULE3
			end
			OP_MUL: begin
				rsp_nxt.wr_lo = 1'b1;
				rsp_nxt.lo_data = prod[TMD_XLEN-1:0]; // RULE4
				if (req_i.set_flags) begin
					rsp_nxt.flags.n = prod[TMD_XLEN-1]; // RULE8
					rsp_nxt.flags.z = (prod[TMD_XLEN-1:0] == '0);
					rsp_nxt.flag_we = '{n: 1'b1, z: 1'b1, c: 1'b0, v: 1'b0}; // RULE8
				end
			end
			OP_MLA: begin
				rsp_nxt.wr_lo = 1'b1;
				rsp_nxt.lo_data = mla_res; // RULE5
			end
			OP_MLS: begin
				rsp_nxt.wr_lo = 1'b1;
				rsp_nxt.lo_data = mls_res; // RULE6
			end
			OP_ULONG, OP_SLONG: begin
				// flag_we stays clear for every long form
				rsp_nxt.wr_lo = 1'b1; // RULE11
				rsp_nxt.wr_hi = 1'b1; // RULE15
				rsp_nxt.lo_idx = req_i.rd_idx;
				rsp_nxt.lo_data = prod[TMD_XLEN-1:0];
				rsp_nxt.hi_data = prod[2*TMD_XLEN-1:TMD_XLEN];
			end
			OP_ULONG_ACC, OP_SLONG_ACC: begin
				rsp_nxt.wr_lo = 1'b1; // RULE12
				rsp_nxt.wr_hi = 1'b1; // RULE14
				rsp_nxt.lo_idx = req_i.rd_idx;
				rsp_nxt.lo_data = long_sum[TMD_XLEN-1:0];
				rsp_nxt.hi_data = long_sum[2*TMD_XLEN-1:TMD_XLEN];
			end
			OP_SQUOT, OP_UQUOT: begin
				// only the zero divisor ends here; a trap suppresses the write
				rsp_nxt.wr_lo = !ctrl_trap_r; // RULE21
			end
			default: begin
				rsp_nxt.wr_lo = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// divider
	tmd_divider #(
		.W(TMD_XLEN)
	) u_div (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.start_i(div_go),
		.signed_i(req_i.op == OP_SQUOT),
		.dividend_i(req_i.first),
		.divisor_i(req_i.second),
		.busy_o(div_busy),
		.done_o(div_done),
		.quotient_o(quotient)
	);

	// sequencing: one divide blocks new requests until it answers
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (div_go) begin
					state_nxt = ST_DIV;
				end
			end
			ST_DIV: begin
				if (div_done) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// destination of the divide in flight
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pend_idx_r <= '0;
		end else if (div_go) begin
			pend_idx_r <= dflt_idx;
		end
	end

	// ==========================================================
	// answer register
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rsp_r <= '0;
			rsp_valid_r <= 1'b0;
		end else if (div_done) begin
			rsp_r <= '0;
			rsp_r.wr_lo <= 1'b1; // RULE17
			rsp_r.lo_idx <= pend_idx_r;
			rsp_r.lo_data <= quotient; // RULE18
			rsp_r.flags <= flags_i; // RULE20
			rsp_valid_r <= 1'b1;
		end else if (take && !div_go) begin
			rsp_r <= rsp_nxt;
			rsp_valid_r <= 1'b1;
		end else begin
			rsp_valid_r <= 1'b0;
		end
	end

	// trap pulse beside the answer of a trapped zero divide
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			trap_r <= 1'b0;
		end else begin
			trap_r <= take && is_div && div_zero && ctrl_trap_r;
		end
	end

	assign rsp_valid_o = rsp_valid_r;
	assign rsp_o = rsp_r;
	assign div_trap_o = trap_r;

	// ==========================================================
	// control register
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_trap_r <= TMD_CTRL_TRAP_RST;
		end else if (reg_wr_i && reg_addr_i == TMD_REG_CTRL) begin
			ctrl_trap_r <= reg_wdata_i[TMD_CTRL_TRAP_BIT];
		end
	end

	// sticky zero-divisor flag; a new event beats a clear in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dz_r <= 1'b0;
		end else if (take && is_div && div_zero) begin
			dz_r <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == TMD_REG_STAT && reg_wdata_i[TMD_STAT_DZ_BIT]) begin
			dz_r <= 1'b0;
		end
	end

	// answered operations; a clearing write in an answer cycle restarts the count at one
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ops_r <= '0;
		end else if (rsp_valid_r) begin
			ops_r <= (reg_wr_i && reg_addr_i == TMD_REG_OPS) ? TMD_XLEN'(1) : ops_r + 1'b1;
		end else if (reg_wr_i && reg_addr_i == TMD_REG_OPS) begin
			ops_r <= '0;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_r <= '0;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				TMD_REG_CTRL: rdata_r <= TMD_XLEN'(ctrl_trap_r) << TMD_CTRL_TRAP_BIT;
				TMD_REG_STAT: rdata_r <= (TMD_XLEN'(div_busy) << TMD_STAT_BUSY_BIT)
					| (TMD_XLEN'(dz_r) << TMD_STAT_DZ_BIT);
				TMD_REG_OPS: rdata_r <= ops_r;
				default: rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end

	assign reg_rdata_o = rdata_r;

	// ==========================================================
	// checks
	a_test_no_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE1
		take && (req_i.op == OP_TEST_AND || req_i.op == OP_TEST_XOR)
		|=> rsp_valid_o && !rsp_o.wr_lo && !rsp_o.wr_hi)
		else $error("test operation wrote a register");
	a_test_xor_sign: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE2
		take && req_i.op == OP_TEST_XOR
		|=> rsp_o.flags.n == ($past(req_i.first[TMD_XLEN-1]) ^ $past(req_i.second[TMD_XLEN-1])))
		else $error("equivalence test sign wrong");
	a_test_v_kept: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE3
		take && (req_i.op == OP_TEST_AND || req_i.op == OP_TEST_XOR)
		|=> rsp_o.flag_we.n && rsp_o.flag_we.z && !rsp_o.flag_we.v)
		else $error("test flags mask wrong");
	a_mul_low_word: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE4
		take && req_i.op == OP_MUL
		|=> rsp_o.wr_lo && rsp_o.lo_data == TMD_XLEN'($past(req_i.first) * $past(req_i.second)))
		else $error("low word product wrong");
	a_mul_flags_nz: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE8
		take && req_i.op == OP_MUL && req_i.set_flags
		|=> rsp_o.flag_we == '{n: 1'b1, z: 1'b1, c: 1'b0, v: 1'b0})
		else $error("flag multiply mask wrong");
	a_mul_dest_dflt: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE10
		take && req_i.op inside {OP_MUL, OP_MLA, OP_MLS} && !req_i.rd_given
		|=> rsp_o.lo_idx == $past(req_i.rn_idx))
		else $error("default destination wrong");
	a_long_no_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE15
		take && req_i.op inside {OP_ULONG, OP_ULONG_ACC, OP_SLONG, OP_SLONG_ACC}
		|=> rsp_o.flag_we == '0 && rsp_o.wr_lo && rsp_o.wr_hi)
		else $error("long multiply touched flags");
	a_div_answer: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE20
		div_go |=> !req_ready_o [*8] ##26 (rsp_valid_o && rsp_o.flag_we == '0 && rsp_o.wr_lo))
		else $error("divide answer late or changed flags");
	a_div_zero_res: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RULE21
		take && is_div && div_zero && !ctrl_trap_r
		|=> rsp_valid_o && rsp_o.wr_lo && rsp_o.lo_data == '0 && rsp_o.flag_we == '0)
		else $error("zero divisor result wrong");
endmodule // tmd_unit

// file: test/tmd_core_model.sv
// Purpose: core-side partner of the unit: status flags and register file
// Assumes: one answer at a time; write enables qualify each half of it
// Notes: the bench presets the flags through a set strobe before a request
module tmd_core_model (
	input wire logic core_clk_i,                 // core clock
	input wire logic rst_n_i,                    // sync reset, active low
	input wire logic rsp_valid_i,                // answer strobe
	input wire tmd_pkg::tmd_rsp_t rsp_i,         // writeback and flags
	input wire logic flag_set_i,                 // preset strobe
	input wire tmd_pkg::tmd_flags_t flag_val_i,  // preset value
	output tmd_pkg::tmd_flags_t flags_o          // flags seen by the unit
);
	timeunit 1ns;
	timeprecision 1ps;
	import tmd_pkg::*;
	logic [31:0] regs_r [16];

	// ==========================================================
	// flags: only bits with a write enable move, so a stray enable shows later
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			flags_o <= '0;
		end else if (flag_set_i) begin
			flags_o <= flag_val_i;
		end else if (rsp_valid_i) begin
			flags_o <= tmd_flags_t'((rsp_i.flags & rsp_i.flag_we) | (flags_o & ~rsp_i.flag_we));
		end
	end

	// ==========================================================
	// register file: both halves of a long result land at one edge
	always_ff @(posedge core_clk_i) begin
		if (rsp_valid_i && rsp_i.wr_lo) begin
			regs_r[rsp_i.lo_idx] <= rsp_i.lo_data;
		end
		if (rsp_valid_i && rsp_i.wr_hi) begin
			regs_r[rsp_i.hi_idx] <= rsp_i.hi_data;
		end
	end
endmodule // tmd_core_model

// file: test/test_multiply_divide_unit_tb.sv
// Purpose: self-checking bench of the test, multiply and divide unit
// Assumes: one request in flight; flags come from the core model
// Notes: indices fixed: destination 2, first source 5, result high 3
module test_multiply_divide_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tmd_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	tmd_req_t req = '0;
	logic fset = 1'b0;
	tmd_flags_t fval = '0;
	tmd_flags_t flags;
	logic req_ready_o, rsp_valid_o, div_trap_o;
	tmd_rsp_t rsp_o;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata_o;
	int err_total = 0;
	int num_checks = 0;
	int lat;
	logic rdy1, trap1;
	logic [31:0] d;

	tmd_unit dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_ready_o(req_ready_o),
		.req_i(req), .flags_i(flags), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .div_trap_o(div_trap_o),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata_o));
	tmd_core_model core (.core_clk_i(core_clk), .rst_n_i(rst_n), .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o),
		.flag_set_i(fset), .flag_val_i(fval), .flags_o(flags));

	// ==========================================================
	// clock, 4 ns period
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic conclude();
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ==========================================================
	// request driver: preset flags, hold valid for one cycle, then count edges to the answer
	task automatic issue(input tmd_op_t op, input logic sf, rdg, input logic [31:0] a, b, ad, ahi, alo,
		input logic [3:0] f);
		@(posedge core_clk);
		fset <= 1'b1;
		fval <= tmd_flags_t'(f);
		@(posedge core_clk);
		fset <= 1'b0;
		req_valid <= 1'b1;
		req <= '{op: op, set_flags: sf, shift_c: 1'b1, shift_c_vld: 1'b1, rd_given: rdg, rd_idx: 4'h2,
			rn_idx: 4'h5, rhi_idx: 4'h3, first: a, second: b, addend: ad, acc_hi: ahi, acc_lo: alo};
		@(posedge core_clk);
		req_valid <= 1'b0;
		#1;
		lat = 1;
		rdy1 = req_ready_o;
		trap1 = div_trap_o;
		while (rsp_valid_o !== 1'b1 && lat < 40) begin
			@(posedge core_clk);
			#1;
			lat++;
		end
	endtask

	task automatic expect_rsp(input int el, input logic wl, wh, input logic [3:0] li, input logic [31:0] lo, hi,
		input logic [3:0] we, fl);
		chk(lat, el);
		chk(rdy1, el == 1);
		chk(rsp_o.wr_lo, wl);
		chk(rsp_o.wr_hi, wh);
		chk(rsp_o.flag_we, we);
		chk(rsp_o.flags, fl);
		if (wl) chk({rsp_o.lo_idx, rsp_o.lo_data}, {li, lo});
		if (wh) chk({rsp_o.hi_idx, rsp_o.hi_data}, {4'h3, hi});
	endtask

	task automatic reg_write(input logic [7:0] ad, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] ad, output logic [31:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata_o;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_tests();
		issue(OP_TEST_AND, 1'b0, 1'b1, 32'h8000_0F00, 32'h8000_00F0, 32'h0, 32'h0, 32'h0, 4'h1);
		expect_rsp(1, 1'b0, 1'b0, 4'h2, 32'h0, 32'h0, 4'hE, 4'hB);
		issue(OP_TEST_XOR, 1'b0, 1'b1, 32'h1234_5678, 32'h1234_5678, 32'h0, 32'h0, 32'h0, 4'h9);
		expect_rsp(1, 1'b0, 1'b0, 4'h2, 32'h0, 32'h0, 4'hE, 4'h7);
	endtask

	task automatic t_mul();
		// flag-update form only with low indices, no condition
		issue(OP_MUL, 1'b1, 1'b0, 32'hFFFF_FFFD, 32'h0000_0007, 32'h0, 32'h0, 32'h0, 4'h7);
		expect_rsp(1, 1'b1, 1'b0, 4'h5, 32'hFFFF_FFEB, 32'h0, 4'hC, 4'hB);
		issue(OP_MUL, 1'b1, 1'b1, 32'h0001_0000, 32'h0001_0000, 32'h0, 32'h0, 32'h0, 4'h8);
		expect_rsp(1, 1'b1, 1'b0, 4'h2, 32'h0, 32'h0, 4'hC, 4'h4);
		issue(OP_MLA, 1'b0, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h5, 32'h0, 32'h0, 4'h5);
		expect_rsp(1, 1'b1, 1'b0, 4'h2, 32'h6, 32'h0, 4'h0, 4'h5);
		issue(OP_MLS, 1'b0, 1'b1, 32'h3, 32'h4, 32'h5, 32'h0, 32'h0, 4'hA);
		expect_rsp(1, 1'b1, 1'b0, 4'h2, 32'hFFFF_FFF9, 32'h0, 4'h0, 4'hA);
	endtask

	task automatic t_long();
		tmd_op_t ops [4] = '{OP_ULONG, OP_ULONG_ACC, OP_SLONG, OP_SLONG_ACC};
		logic [31:0] a [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFE};
		logic [31:0] b [4] = '{32'hFFFF_FFFF, 32'h0000_0002, 32'h0000_0003, 32'h0000_0003};
		logic [63:0] acc [4] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 64'h10};
		logic [63:0] e;
		for (int k = 0; k < 4; k++) begin
			e = (k < 2) ? {32'h0, a[k]} * {32'h0, b[k]} : {{32{a[k][31]}}, a[k]} * {{32{b[k][31]}}, b[k]};
			if (k == 1 || k == 3) e = e + acc[k];
			// low half to index 2, high half to index 3, never the same
			issue(ops[k], 1'b0, 1'b1, a[k], b[k], 32'h0, acc[k][63:32], acc[k][31:0], 4'hF);
			expect_rsp(1, 1'b1, 1'b1, 4'h2, e[31:0], e[63:32], 4'h0, 4'hF);
		end
		@(posedge core_clk);
		#1;
		chk({core.regs_r[3], core.regs_r[2]}, e);
	endtask

	task automatic t_div();
		logic [31:0] a [5] = '{32'hFFFF_FFF9, 32'hFFFF_FFF9, 32'h0000_0007, 32'h0000_0005, 32'hFFFF_FFF9};
		logic [31:0] b [5] = '{32'h0000_0002, 32'h0000_0002, 32'hFFFF_FFFE, 32'h0000_0000, 32'h0000_0000};
		logic [31:0] e;
		logic sg;
		for (int k = 0; k < 5; k++) begin
			sg = (k != 1 && k != 3);
			e = (b[k] == 32'h0) ? 32'h0 : sg ? 32'($signed(a[k]) / $signed(b[k])) : a[k] / b[k];
			issue(sg ? OP_SQUOT : OP_UQUOT, 1'b0, 1'b0, a[k], b[k], 32'h0, 32'h0, 32'h0, 4'hA);
			expect_rsp((b[k] == 32'h0) ? 1 : 34, 1'b1, 1'b0, 4'h5, e, 32'h0, 4'h0, 4'hA);
			chk(trap1, 1'b0);
		end
	endtask

	// register port: sticky zero-divisor flag, trap enable, answer counter, hole
	task automatic t_trap();
		reg_read(TMD_REG_STAT, d);
		chk(d, 32'h2);
		reg_write(TMD_REG_STAT, 32'h2);
		reg_read(TMD_REG_STAT, d);
		chk(d, 32'h0);
		reg_write(TMD_REG_CTRL, 32'h1);
		reg_write(TMD_REG_OPS, 32'h0);
		issue(OP_UQUOT, 1'b0, 1'b1, 32'h9, 32'h0, 32'h0, 32'h0, 32'h0, 4'h3);
		chk(trap1, 1'b1);
		expect_rsp(1, 1'b0, 1'b0, 4'h2, 32'h0, 32'h0, 4'h0, 4'h3);
		reg_read(TMD_REG_OPS, d);
		chk(d, 32'h1);
		reg_read(8'h0C, d);
		chk(d, 32'h0);
		@(posedge core_clk);
		#1;
		chk(reg_rdata_o, 32'h0);
	endtask

	// ==========================================================
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		err_total++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		#1;
		chk({req_ready_o, rsp_valid_o, div_trap_o}, 3'h4);
		t_tests();
		t_mul();
		t_long();
		t_div();
		t_trap();
		conclude();
	end
endmodule // test_multiply_divide_unit_tb
